// *** src/fac_pkg.sv ***
/*
 * shared constants and types for the feedback acquisition control block.
 * assumes a single 25 MHz processing clock and a host that polls once a second.
 */
package fac_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int FAC_DATA_W = 16;
  localparam int FAC_COEF_W = 16;
  localparam int FAC_TAPS = 8;
  localparam int FAC_SHIFT_W = 3;
  localparam int FAC_LEN_W = 24;
  localparam int FAC_DEC_W = 8;
  localparam int FAC_CNT_W = 32;
  localparam int FAC_PCT_W = 7;
  localparam int FAC_HOLD_GROUP = 4;
  localparam logic [FAC_LEN_W-1:0] FAC_MAX_LEN_ONCHIP = 24'h020000;
  localparam logic [FAC_LEN_W-1:0] FAC_MAX_LEN_EXTERN = 24'h800000;
  localparam logic [FAC_PCT_W-1:0] FAC_PCT_FULL = 7'h64;
  localparam logic [FAC_DEC_W-1:0] FAC_DEC_RESET = 8'h00;
  // ----------------------------------------------------------------
  // fiducial timing: expected period in clocks and tolerated jitter; rf tick timeout in clocks
  // ----------------------------------------------------------------
  localparam logic [15:0] FAC_FID_PERIOD = 16'h0100;
  localparam logic [15:0] FAC_FID_TOL = 16'h0002;
  localparam logic [15:0] FAC_RF_TIMEOUT = 16'h0040;

  typedef enum logic [2:0] {
    FAC_IDLE,
    FAC_ARMED,
    FAC_HOLDOFF,
    FAC_CAPTURE,
    FAC_DONE
  } fac_acq_state_t;
endpackage

// *** src/fac_dec_if.sv ***
/*
 * decimation strobe carrier between the top and its decimator.
 * assumes both ends run on the same clock.
 */
interface fac_dec_if;
  import fac_pkg::*;
  logic [FAC_DEC_W-1:0] factor;
  logic restart;
  logic strobe;
  modport ctrl(output factor, output restart, input strobe);
  modport dec(input factor, input restart, output strobe);
endinterface

// *** src/fac_decimator.sv ***
/*
 * decimator: strobes once every factor+1 input samples.
 * assumes i_sample_valid is on the same clock; restart resynchronises phase.
 */
module fac_decimator
  import fac_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_sample_valid,
  fac_dec_if.dec dec
);
  logic [FAC_DEC_W-1:0] cnt_reg;
  logic [FAC_DEC_W-1:0] cnt_next;
  logic strobe_next;

  always_comb begin
    cnt_next = cnt_reg;
    strobe_next = 1'b0;
    if (dec.restart) begin
      cnt_next = '0;
    end else if (i_sample_valid) begin
      if (cnt_reg >= dec.factor) begin
        cnt_next = '0;
        strobe_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
      dec.strobe <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dec.strobe <= strobe_next;
    end
  end
endmodule

// *** src/fac_top.sv ***
/*
 * feedback acquisition control: coefficient sets, gain shift, output gate,
 * saturation duty detector, grow/damp switching, acquisition sequencer and
 * clock/fiducial status. assumes sample data arrives on i_sys_clk with a
 * valid strobe; external pins are asynchronous and are synchronised here.
 */
import fac_pkg::*;

// How it works
// RULE_01: integrate saturation, compare percent duty threshold
// RULE_02: poll reads result, then counter clears
// RULE_03: zero threshold flags any single saturation
// RULE_04: each shift step doubles output gain
// RULE_05: two loadable, readable coefficient sets
// RULE_06: selector picks active coefficient set
// RULE_07: set_switch_enable allows switching in acquisition
// RULE_08: invert set select for grow length
// RULE_09: hold-off inverts select, groups of four
// RULE_10: acquisition decimation independent of processing
// RULE_11: record length capped per memory type
// RULE_12: memory select picks onchip or external
// RULE_13: trigger source internal or external input
// RULE_14: internal source starts on software trigger
// RULE_15: external trigger ignored unless armed
// RULE_16: auto rearm after each readout
// RULE_17: feedback enable gates output to converter
// RULE_18: flags rf missing and clock lock losses
// RULE_19: fiducial missing or jitter raises error
// RULE_20: count polls, reset clears error counters
// RULE_21: write decimated samples until length, done
module fac_top
  import fac_pkg::*;
#(
  parameter int DATA_W = FAC_DATA_W,
  parameter int TAPS = FAC_TAPS
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_sample_valid,
  input wire logic signed [DATA_W-1:0] i_filter_out,
  input wire logic i_feedback_enable,
  input wire logic [FAC_SHIFT_W-1:0] i_gain_shift,
  input wire logic i_coef_set_select,
  input wire logic i_coef_wr,
  input wire logic i_coef_wr_set,
  input wire logic [2:0] i_coef_addr,
  input wire logic [FAC_COEF_W-1:0] i_coef_wdata,
  input wire logic i_coef_rd_set,
  input wire logic [FAC_PCT_W-1:0] i_saturation_duty_threshold,
  input wire logic i_poll,
  input wire logic i_set_switch_enable,
  input wire logic [FAC_LEN_W-1:0] i_grow_length,
  input wire logic [15:0] i_holdoff_groups,
  input wire logic [FAC_DEC_W-1:0] i_acquisition_decimation,
  input wire logic [FAC_LEN_W-1:0] i_record_length,
  input wire logic i_capture_memory_select,
  input wire logic i_trigger_source_ext,
  input wire logic i_soft_trigger,
  input wire logic i_arm,
  input wire logic i_automatic_rearm,
  input wire logic i_readout_done,
  input wire logic i_external_trigger_input,
  input wire logic i_rf_clock_tick,
  input wire logic i_processing_clock_lock,
  input wire logic i_acquisition_clock_lock,
  input wire logic i_fiducial,
  input wire logic i_error_reset,
  output logic signed [DATA_W-1:0] o_dac_data,
  output logic o_active_set,
  output logic [FAC_COEF_W-1:0] o_coef_rdata,
  output logic o_saturation_flag,
  output logic o_onchip_we,
  output logic o_extern_we,
  output logic [FAC_LEN_W-1:0] o_mem_addr,
  output logic [DATA_W-1:0] o_mem_data,
  output logic o_armed,
  output logic o_acq_busy,
  output logic o_acq_done,
  output logic o_rf_clock_missing,
  output logic o_processing_unlocked,
  output logic o_acquisition_unlocked,
  output logic o_fiducial_error,
  output logic [FAC_CNT_W-1:0] o_interval,
  output logic [FAC_CNT_W-1:0] o_error_count
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] trig_sync_reg, rf_sync_reg, fid_sync_reg;
  logic [1:0] plock_sync_reg, alock_sync_reg;
  logic trig_prev_reg, rf_prev_reg, fid_prev_reg;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      trig_sync_reg <= '0;
      rf_sync_reg <= '0;
      fid_sync_reg <= '0;
      plock_sync_reg <= '0;
      alock_sync_reg <= '0;
      trig_prev_reg <= 1'b0;
      rf_prev_reg <= 1'b0;
      fid_prev_reg <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[0], i_external_trigger_input};
      rf_sync_reg <= {rf_sync_reg[0], i_rf_clock_tick};
      fid_sync_reg <= {fid_sync_reg[0], i_fiducial};
      plock_sync_reg <= {plock_sync_reg[0], i_processing_clock_lock};
      alock_sync_reg <= {alock_sync_reg[0], i_acquisition_clock_lock};
      trig_prev_reg <= trig_sync_reg[1];
      rf_prev_reg <= rf_sync_reg[1];
      fid_prev_reg <= fid_sync_reg[1];
    end
  end
  logic ext_trig_rise, rf_edge, fid_rise;
  assign ext_trig_rise = trig_sync_reg[1] & ~trig_prev_reg;
  assign rf_edge = rf_sync_reg[1] ^ rf_prev_reg;
  assign fid_rise = fid_sync_reg[1] & ~fid_prev_reg;

  // ----------------------------------------------------------------
  // coefficient sets and output path
  // ----------------------------------------------------------------
  // storage is flat flip-flops; the filter datapath itself lives elsewhere
  logic [FAC_COEF_W-1:0] coef_reg [2][TAPS];
  logic [FAC_COEF_W-1:0] coef_rdata_next;
  logic signed [DATA_W-1:0] dac_next;
  logic sat_now;
  logic invert_reg, invert_next;
  logic active_next;
  logic signed [2*DATA_W-1:0] shifted;
  localparam logic signed [DATA_W-1:0] OUT_MAX = {1'b0, {(DATA_W-1){1'b1}}};
  localparam logic signed [DATA_W-1:0] OUT_MIN = {1'b1, {(DATA_W-1){1'b0}}};

  always_comb begin
    coef_rdata_next = coef_reg[i_coef_rd_set][i_coef_addr]; // [RULE_05]
    active_next = i_coef_set_select ^ invert_reg; // [RULE_06] [RULE_08]
    shifted = (2*DATA_W)'(i_filter_out) <<< i_gain_shift; // [RULE_04]
    sat_now = (shifted > OUT_MAX) || (shifted < OUT_MIN);
    if (shifted[2*DATA_W-1]) begin
      dac_next = sat_now ? OUT_MIN : shifted[DATA_W-1:0];
    end else begin
      dac_next = sat_now ? OUT_MAX : shifted[DATA_W-1:0];
    end
    if (!i_feedback_enable) begin
      dac_next = '0; // [RULE_17]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int s = 0; s < 2; s++) begin
        for (int t = 0; t < TAPS; t++) begin
          coef_reg[s][t] <= '0;
        end
      end
      o_coef_rdata <= '0;
      o_dac_data <= '0;
      o_active_set <= 1'b0;
    end else begin
      if (i_coef_wr) begin
        coef_reg[i_coef_wr_set][i_coef_addr] <= i_coef_wdata; // [RULE_05]
      end
      o_coef_rdata <= coef_rdata_next;
      o_dac_data <= dac_next;
      o_active_set <= active_next;
    end
  end

  // ----------------------------------------------------------------
  // saturation duty detector
  // ----------------------------------------------------------------
  logic [FAC_CNT_W-1:0] sat_cnt_reg, sat_cnt_next;
  logic [FAC_CNT_W-1:0] smp_cnt_reg, smp_cnt_next;
  logic sat_flag_next;
  logic [FAC_CNT_W+6:0] sat_scaled, smp_scaled;
  always_comb begin
    sat_cnt_next = sat_cnt_reg;
    smp_cnt_next = smp_cnt_reg;
    sat_flag_next = o_saturation_flag;
    sat_scaled = 39'(sat_cnt_reg) * 39'(FAC_PCT_FULL);
    smp_scaled = 39'(smp_cnt_reg) * 39'(i_saturation_duty_threshold);
    if (i_poll) begin
      // result latched for the host, then counter zeroed [RULE_02]
      if (i_saturation_duty_threshold == '0) begin
        sat_flag_next = (sat_cnt_reg != '0); // [RULE_03]
      end else begin
        sat_flag_next = (smp_cnt_reg != '0) &&
                        (sat_scaled >= smp_scaled); // [RULE_01]
      end
      sat_cnt_next = '0;
      smp_cnt_next = '0;
    end else if (i_sample_valid) begin
      smp_cnt_next = smp_cnt_reg + 32'h1;
      if (sat_now) begin
        sat_cnt_next = sat_cnt_reg + 32'h1; // [RULE_01]
      end
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sat_cnt_reg <= '0;
      smp_cnt_reg <= '0;
      o_saturation_flag <= 1'b0;
    end else begin
      sat_cnt_reg <= sat_cnt_next;
      smp_cnt_reg <= smp_cnt_next;
      o_saturation_flag <= sat_flag_next;
    end
  end

  // ----------------------------------------------------------------
  // acquisition sequencer
  // ----------------------------------------------------------------
  fac_dec_if dec_bus();
  fac_decimator u_dec (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_sample_valid(i_sample_valid),
    .dec(dec_bus.dec)
  );
  fac_acq_state_t st_reg, st_next;
  logic [FAC_LEN_W-1:0] idx_reg, idx_next, len_lim;
  logic [FAC_LEN_W-1:0] grow_reg, grow_next;
  logic [17:0] hold_reg, hold_next;
  logic armed_next, trig_ok, done_next;
  logic onchip_we_next, extern_we_next;

  always_comb begin
    // [RULE_11] clamp length to the selected memory's depth
    len_lim = i_capture_memory_select ?
      ((i_record_length > FAC_MAX_LEN_EXTERN) ? FAC_MAX_LEN_EXTERN :
       i_record_length) :
      ((i_record_length > FAC_MAX_LEN_ONCHIP) ? FAC_MAX_LEN_ONCHIP :
       i_record_length);
    dec_bus.factor = i_acquisition_decimation; // [RULE_10]
    dec_bus.restart = 1'b0;
    st_next = st_reg;
    idx_next = idx_reg;
    grow_next = grow_reg;
    hold_next = hold_reg;
    invert_next = 1'b0;
    armed_next = o_armed;
    done_next = o_acq_done;
    onchip_we_next = 1'b0;
    extern_we_next = 1'b0;
    // [RULE_13] [RULE_14] [RULE_15]
    trig_ok = i_trigger_source_ext ? (ext_trig_rise && o_armed) :
              i_soft_trigger;
    if (i_arm || (i_automatic_rearm && i_readout_done)) begin
      armed_next = 1'b1; // [RULE_16]
    end
    unique case (st_reg)
      FAC_IDLE, FAC_DONE: begin
        if (trig_ok && len_lim != '0) begin
          armed_next = 1'b0;
          done_next = 1'b0;
          idx_next = '0;
          grow_next = i_grow_length;
          hold_next = 18'(i_holdoff_groups) * 18'(FAC_HOLD_GROUP); // [RULE_09]
          dec_bus.restart = 1'b1;
          st_next = FAC_HOLDOFF;
        end
      end
      FAC_ARMED: st_next = FAC_IDLE;
      FAC_HOLDOFF: begin
        invert_next = i_set_switch_enable &&
                      (hold_reg != '0 || grow_reg != '0); // [RULE_09]
        if (hold_reg == '0) begin
          st_next = FAC_CAPTURE;
        end else if (i_sample_valid) begin
          hold_next = hold_reg - 18'h1;
        end
      end
      FAC_CAPTURE: begin
        // [RULE_07] [RULE_08] inverted only while grow samples remain
        invert_next = i_set_switch_enable && grow_reg != '0;
        if (dec_bus.strobe) begin
          onchip_we_next = ~i_capture_memory_select; // [RULE_12]
          extern_we_next = i_capture_memory_select;
          idx_next = idx_reg + 24'h1; // [RULE_21]
          if (grow_reg != '0) begin
            grow_next = grow_reg - 24'h1;
          end
          if (idx_reg + 24'h1 >= len_lim) begin
            st_next = FAC_DONE;
            done_next = 1'b1; // [RULE_21]
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= FAC_IDLE;
      idx_reg <= '0;
      grow_reg <= '0;
      hold_reg <= '0;
      invert_reg <= 1'b0;
      o_armed <= 1'b0;
      o_acq_done <= 1'b0;
      o_acq_busy <= 1'b0;
      o_onchip_we <= 1'b0;
      o_extern_we <= 1'b0;
      o_mem_addr <= '0;
      o_mem_data <= '0;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      grow_reg <= grow_next;
      hold_reg <= hold_next;
      invert_reg <= invert_next;
      o_armed <= armed_next;
      o_acq_done <= done_next;
      o_acq_busy <= (st_next == FAC_HOLDOFF) || (st_next == FAC_CAPTURE);
      o_onchip_we <= onchip_we_next;
      o_extern_we <= extern_we_next;
      o_mem_addr <= idx_reg;
      o_mem_data <= i_filter_out;
    end
  end

  // ----------------------------------------------------------------
  // clock, lock and fiducial status
  // ----------------------------------------------------------------
  logic [15:0] rf_to_reg, rf_to_next, fid_cnt_reg, fid_cnt_next;
  logic fid_err_next, err_event;
  logic [FAC_CNT_W-1:0] intv_next, errc_next;
  always_comb begin
    rf_to_next = rf_edge ? 16'h0000 :
      ((rf_to_reg == FAC_RF_TIMEOUT) ? rf_to_reg : rf_to_reg + 16'h1);
    fid_cnt_next = (fid_cnt_reg == 16'hFFFF) ? fid_cnt_reg :
                   fid_cnt_reg + 16'h1;
    fid_err_next = 1'b0;
    // missing: no edge by period plus tolerance; jitter: edge off period
    if (fid_cnt_reg > FAC_FID_PERIOD + FAC_FID_TOL) begin
      fid_err_next = 1'b1; // [RULE_19]
    end
    if (fid_rise) begin
      fid_cnt_next = 16'h0001;
      if (fid_cnt_reg + FAC_FID_TOL < FAC_FID_PERIOD) begin
        fid_err_next = 1'b1; // [RULE_19]
      end
    end
    err_event = o_rf_clock_missing | o_processing_unlocked |
                o_acquisition_unlocked | o_fiducial_error;
    intv_next = o_interval;
    errc_next = o_error_count;
    if (i_error_reset) begin
      intv_next = '0; // [RULE_20]
      errc_next = '0;
    end else if (i_poll) begin
      intv_next = o_interval + 32'h1; // [RULE_20]
      errc_next = o_error_count + 32'(err_event);
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rf_to_reg <= '0;
      fid_cnt_reg <= '0;
      o_rf_clock_missing <= 1'b0;
      o_processing_unlocked <= 1'b0;
      o_acquisition_unlocked <= 1'b0;
      o_fiducial_error <= 1'b0;
      o_interval <= '0;
      o_error_count <= '0;
    end else begin
      rf_to_reg <= rf_to_next;
      fid_cnt_reg <= fid_cnt_next;
      o_rf_clock_missing <= (rf_to_next == FAC_RF_TIMEOUT); // [RULE_18]
      o_processing_unlocked <= ~plock_sync_reg[1]; // [RULE_18]
      o_acquisition_unlocked <= ~alock_sync_reg[1]; // [RULE_18]
      o_fiducial_error <= fid_err_next;
      o_interval <= intv_next;
      o_error_count <= errc_next;
    end
  end
endmodule

// *** verification/fac_top_properties.sv ***
/*
 * concurrent checks on the ports of the feedback acquisition control top.
 * assumes one clock domain and an asynchronous active-high reset.
 */
module fac_top_checker
  import fac_pkg::*;
#(
  parameter int DATA_W = FAC_DATA_W
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic signed [DATA_W-1:0] i_filter_out,
  input wire logic i_feedback_enable,
  input wire logic [FAC_SHIFT_W-1:0] i_gain_shift,
  input wire logic [FAC_LEN_W-1:0] i_record_length,
  input wire logic i_capture_memory_select,
  input wire logic i_trigger_source_ext,
  input wire logic i_arm,
  input wire logic i_automatic_rearm,
  input wire logic i_readout_done,
  input wire logic i_poll,
  input wire logic i_error_reset,
  input wire logic i_processing_clock_lock,
  input wire logic signed [DATA_W-1:0] o_dac_data,
  input wire logic o_onchip_we,
  input wire logic o_extern_we,
  input wire logic [FAC_LEN_W-1:0] o_mem_addr,
  input wire logic o_armed,
  input wire logic o_acq_busy,
  input wire logic o_acq_done,
  input wire logic o_processing_unlocked,
  input wire logic [FAC_CNT_W-1:0] o_interval,
  input wire logic [FAC_CNT_W-1:0] o_error_count
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  AST_FB_GATE: assert property (
    !i_feedback_enable |=> o_dac_data == '0)
    else $error("output not gated off");
  AST_GAIN_UNITY: assert property (
    i_feedback_enable && i_gain_shift == 3'h0 |=>
    o_dac_data == $past(i_filter_out))
    else $error("unity gain output wrong");
  AST_EXT_NEEDS_ARM: assert property (
    $rose(o_acq_busy) && i_trigger_source_ext |-> $past(o_armed))
    else $error("external capture started unarmed");
  AST_MEM_SELECT: assert property (
    o_onchip_we || o_extern_we |->
    o_extern_we == i_capture_memory_select && !(o_onchip_we && o_extern_we))
    else $error("write went to the wrong memory");
  AST_DONE_ADDR: assert property (
    $rose(o_acq_done) && i_record_length <= FAC_MAX_LEN_ONCHIP |->
    o_mem_addr == i_record_length - 24'h1)
    else $error("record ended at wrong address");
  AST_ARM_SETS: assert property (
    i_arm || (i_automatic_rearm && i_readout_done) |=> o_armed)
    else $error("arm request not taken");
  AST_POLL_COUNT: assert property (
    i_poll && !i_error_reset |=> o_interval == $past(o_interval) + 32'h1)
    else $error("interval did not advance on poll");
  AST_ERR_CLEAR: assert property (
    i_error_reset |=> o_interval == '0 && o_error_count == '0)
    else $error("counters not cleared");
  AST_LOCK_FLAG: assert property (
    (!i_processing_clock_lock) [*5] |-> o_processing_unlocked)
    else $error("lock loss not flagged");
endmodule

bind fac_top fac_top_checker #(.DATA_W(DATA_W)) u_fac_top_checker (
  .i_sys_clk, .i_reset, .i_filter_out, .i_feedback_enable, .i_gain_shift,
  .i_record_length, .i_capture_memory_select, .i_trigger_source_ext,
  .i_arm, .i_automatic_rearm, .i_readout_done, .i_poll, .i_error_reset,
  .i_processing_clock_lock, .o_dac_data, .o_onchip_we, .o_extern_we,
  .o_mem_addr, .o_armed, .o_acq_busy, .o_acq_done, .o_processing_unlocked,
  .o_interval, .o_error_count
);

// *** verification/fac_host_model.sv ***
/*
 * host model: forwards poll requests and reads out a finished record.
 * assumes the bench asks for polls and the block flags completion.
 */
module fac_host_model #(
  parameter int READ_DELAY = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_poll_req,
  input wire logic i_acq_done,
  output logic o_poll,
  output logic o_readout_done
);
  logic done_reg;
  int wait_reg;
  // readout is slow on purpose: rearm must not rely on a prompt host
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      {o_poll, o_readout_done, done_reg} <= 3'h0;
      wait_reg <= 0;
    end else begin
      o_poll <= i_poll_req;
      done_reg <= i_acq_done;
      o_readout_done <= (wait_reg == 1);
      if (i_acq_done && !done_reg) wait_reg <= READ_DELAY;
      else if (wait_reg != 0) wait_reg <= wait_reg - 1;
    end
  end
endmodule

// *** verification/tb_fac_top.sv ***
/*
 * self-checking bench for fac_top with a host model on the poll side.
 * assumes fac_pkg, the design files and the checker are compiled first.
 */
module tb_fac_top
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic i_sys_clk, i_reset, i_sample_valid, i_feedback_enable, i_poll;
  logic i_coef_set_select, i_coef_wr, i_coef_wr_set, i_coef_rd_set;
  logic i_set_switch_enable, i_capture_memory_select, i_arm, i_fiducial;
  logic i_trigger_source_ext, i_soft_trigger, i_automatic_rearm;
  logic i_readout_done, i_external_trigger_input, i_rf_clock_tick;
  logic i_processing_clock_lock, i_acquisition_clock_lock, i_error_reset;
  logic poll_req, rf_run, fid_run, o_active_set, o_saturation_flag;
  logic signed [FAC_DATA_W-1:0] i_filter_out, o_dac_data;
  logic [FAC_SHIFT_W-1:0] i_gain_shift;
  logic [2:0] i_coef_addr;
  logic [FAC_COEF_W-1:0] i_coef_wdata, o_coef_rdata;
  logic [FAC_PCT_W-1:0] i_saturation_duty_threshold;
  logic [FAC_LEN_W-1:0] i_grow_length, i_record_length, o_mem_addr;
  logic [15:0] i_holdoff_groups;
  logic [FAC_DEC_W-1:0] i_acquisition_decimation;
  logic [FAC_DATA_W-1:0] o_mem_data;
  logic o_onchip_we, o_extern_we, o_armed, o_acq_busy, o_acq_done;
  logic o_rf_clock_missing, o_processing_unlocked, o_acquisition_unlocked;
  logic o_fiducial_error;
  logic [FAC_CNT_W-1:0] o_interval, o_error_count;
  int fails, n_tests, n_on, n_ex, cyc, first_we, last_we;

  fac_top u_fac_top (.*);
  fac_host_model #(.READ_DELAY(5)) u_fac_host_model (.i_sys_clk, .i_reset,
    .i_poll_req(poll_req), .i_acq_done(o_acq_done), .o_poll(i_poll),
    .o_readout_done(i_readout_done));

  always #20 i_sys_clk = ~i_sys_clk;

  // rf tick and a clean 256-clock fiducial, plus a write monitor
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    i_rf_clock_tick <= rf_run & cyc[1];
    i_fiducial <= fid_run && (cyc % 256 < 8);
    n_on <= n_on + int'(o_onchip_we === 1'b1);
    n_ex <= n_ex + int'(o_extern_we === 1'b1);
    if (o_onchip_we === 1'b1 || o_extern_we === 1'b1) begin
      if (n_on + n_ex == 0) first_we <= cyc;
      last_we <= cyc;
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_poll();
    poll_req = 1'b1;
    tick(1);
    poll_req = 1'b0;
    tick(3);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (o_acq_done !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    tick(1);
    if (k == 300) fails++;
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_coef();
    {i_coef_wr, i_coef_wr_set, i_coef_addr, i_coef_wdata} = {5'h12, 16'h1234};
    tick(1);
    {i_coef_wr_set, i_coef_wdata} = {1'b1, 16'h5678};
    tick(1);
    i_coef_wr = 1'b0;
    tick(3);
    chk_val(o_coef_rdata, 32'h1234);
    i_coef_rd_set = 1'b1;
    tick(2);
    chk_val(o_coef_rdata, 32'h5678);
  endtask
  task automatic t_gain();
    for (int s = 0; s < 4; s++) begin
      i_gain_shift = s[2:0];
      tick(2);
      chk_val(o_dac_data, 32'h13 << s);
    end
    i_feedback_enable = 1'b0;
    tick(2);
    chk_val(o_dac_data, 32'h0);
    {i_feedback_enable, i_gain_shift} = 4'h8;
  endtask
  task automatic t_sat(input int n_sat, input int n_ok, input logic exp);
    i_gain_shift = 3'h1;
    tick(n_sat);
    i_gain_shift = 3'h0;
    tick(n_ok);
    do_poll();
    chk_val(o_saturation_flag, exp);
  endtask
  task automatic t_soft_acq();
    {n_on, n_ex, i_acquisition_decimation, i_record_length} = {64'h0, 8'h01, 24'h3};
    i_soft_trigger = 1'b1;
    tick(1);
    i_soft_trigger = 1'b0;
    tick(4);
    chk_val(o_acq_busy, 1);
    wait_done();
    chk_val(n_on, 3);
    chk_val(last_we - first_we, 4);
    chk_val(o_acq_busy, 0);
  endtask
  task automatic pulse_ext();
    i_external_trigger_input = 1'b1;
    tick(4);
    i_external_trigger_input = 1'b0;
    tick(2);
  endtask
  task automatic t_ext_acq();
    {i_trigger_source_ext, i_capture_memory_select} = 2'h3;
    {n_on, n_ex, i_acquisition_decimation, i_record_length} = {64'h0, 8'h00, 24'h2};
    pulse_ext();
    tick(8);
    chk_val(n_ex, 0);
    i_arm = 1'b1;
    tick(1);
    {i_arm, i_automatic_rearm} = 2'h1;
    tick(1);
    chk_val(o_armed, 1);
    pulse_ext();
    chk_val(o_armed, 0);
    wait_done();
    chk_val({n_on[15:0], n_ex[15:0]}, 32'h2);
    chk_val(o_mem_data, 32'h13);
    tick(10);
    chk_val(o_armed, 1);
    i_automatic_rearm = 1'b0;
  endtask
  task automatic t_grow();
    {i_trigger_source_ext, i_capture_memory_select, i_set_switch_enable} = 3'h1;
    {i_holdoff_groups, i_grow_length, i_record_length} = {16'h2, 24'h4, 24'h6};
    {n_on, n_ex, i_soft_trigger} = {64'h0, 1'b1};
    tick(1);
    i_soft_trigger = 1'b0;
    tick(5);
    chk_val({o_active_set, n_on[30:0]}, {1'b1, 31'h0});
    wait_done();
    tick(3);
    chk_val({o_active_set, n_on[30:0]}, {1'b0, 31'h6});
    {i_set_switch_enable, i_coef_set_select} = 2'h1;
    tick(2);
    chk_val(o_active_set, 1);
  endtask
  task automatic t_status();
    tick(600);
    i_error_reset = 1'b1;
    tick(1);
    i_error_reset = 1'b0;
    do_poll();
    do_poll();
    chk_val(o_interval, 2);
    chk_val(o_error_count, 0);
    {i_processing_clock_lock, i_acquisition_clock_lock, rf_run, fid_run} = 4'h0;
    tick(600);
    chk_val({o_processing_unlocked, o_acquisition_unlocked}, 3);
    chk_val(o_rf_clock_missing, 1);
    chk_val(o_fiducial_error, 1);
    do_poll();
    chk_val(o_interval, 3);
    chk_val(o_error_count, 1);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {i_sys_clk, i_reset, i_sample_valid, i_feedback_enable} = 4'h7;
    {rf_run, fid_run, i_processing_clock_lock, i_acquisition_clock_lock} = 4'hF;
    {i_coef_set_select, i_coef_wr, i_coef_wr_set, i_coef_rd_set} = 4'h0;
    {poll_req, i_set_switch_enable, i_capture_memory_select, i_arm} = 4'h0;
    {i_trigger_source_ext, i_soft_trigger, i_automatic_rearm} = 3'h0;
    {i_external_trigger_input, i_error_reset, i_rf_clock_tick} = 3'h0;
    {i_fiducial, i_gain_shift, i_coef_addr, i_coef_wdata} = 23'h0;
    {i_filter_out, i_saturation_duty_threshold} = {16'h0013, 7'h00};
    {i_grow_length, i_record_length, i_holdoff_groups} = {48'h3, 16'h0};
    {i_acquisition_decimation, fails, n_tests, cyc} = 104'h0;
    repeat (16) @(posedge i_sys_clk);
    #1 i_reset = 1'b0;
    tick(2);
    t_coef();
    t_gain();
    do_poll();
    i_filter_out = 16'h4000;
    t_sat(1, 4, 1'b1);
    t_sat(0, 4, 1'b0);
    i_saturation_duty_threshold = 7'h32;
    t_sat(60, 20, 1'b1);
    t_sat(20, 60, 1'b0);
    i_filter_out = 16'h0013;
    t_soft_acq();
    t_ext_acq();
    t_grow();
    t_status();
    finish_test();
  end
  // whole run is near 1500 clocks, so over sixteen times that means a hang
  initial begin
    repeat (25000) @(posedge i_sys_clk);
    fails++;
    finish_test();
  end
endmodule
